// *** bench/hlbd_rx_model.sv ***
// hlbd_rx_model: receiving device, frames and checks blocks from the link
// assumes: link handshake txValid_q/txReady, reports each percent-framed block on rxDone
`timescale 1ns/1ps
module hlbd_rx_model (
  input  wire logic        clk_sys,   // clock
  input  wire logic        rst_n,     // reset, active low
  input  wire logic [7:0]  txChar_q,  // link char
  input  wire logic        txValid_q, // link valid
  input  wire logic        stall,     // random back-pressure on
  output logic             txReady,   // link ready
  output logic             rxDone,    // pulse: block ended
  output logic             rxGood,    // block passed checks
  output logic [3:0]       rxType,    // type digit
  output logic [63:0]      rxAddr,    // first number field
  output logic [7:0]       rxCnt,     // object bytes
  output logic [15:0]      rxAcc      // object byte digest
);
  logic [7:0] bufc [0:255];
  logic       inBlk;
  int         cnt;
  int         seed = 15;
  function automatic logic [6:0] cval(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return 7'(c - 8'h30);
    if (c >= 8'h41 && c <= 8'h5a) return 7'(c - 8'h37);
    if (c >= 8'h61 && c <= 8'h7a) return 7'(c - 8'h39);
    return (c == 8'h24) ? 7'h24 : (c == 8'h25) ? 7'h25 : (c == 8'h2e) ? 7'h26 : 7'h27;
  endfunction
  function automatic logic [3:0] hx(input logic [7:0] c);
    return (c <= 8'h39) ? 4'(c - 8'h30) : 4'(c - 8'h37);
  endfunction
  // checks length, checksum, type and fields of one framed block
  task automatic decode();
    logic [7:0] sum; logic [63:0] a; logic [15:0] acc; logic [7:0] nb; logic [3:0] d;
    logic g; int k; int p;
    sum = 8'h00; a = 64'h0; acc = 16'h0; nb = 8'h00;
    for (int i = 0; i < cnt; i++) if (i != 3 && i != 4) sum = sum + 8'(cval(bufc[i]));
    d = hx(bufc[5]);
    k = (d == 4'h0) ? 16 : int'(d);
    for (int i = 0; i < k; i++) a = {a[59:0], hx(bufc[6 + i])};
    p = 6 + k;
    g = ({hx(bufc[0]), hx(bufc[1])} == 8'(cnt)) && (sum == {hx(bufc[3]), hx(bufc[4])});
    g = g && (hx(bufc[2]) inside {4'h6, 4'h3, 4'h8});
    if (hx(bufc[2]) == 4'h6) begin
      for (; p + 1 < cnt; p += 2) begin
        acc = 16'(acc * 16'h3 + 16'({hx(bufc[p]), hx(bufc[p + 1])}));
        nb++;
      end
    end
    if (hx(bufc[2]) != 4'h3) g = g && (p == cnt);
    rxGood <= g;
    rxType <= hx(bufc[2]);
    rxAddr <= a;
    rxCnt <= nb;
    rxAcc <= acc;
    rxDone <= 1'b1;
  endtask
  // back-pressure changes on the falling edge only
  always @(negedge clk_sys) txReady <= stall ? ($random(seed) % 3 != 0) : 1'b1;
  // frames on the percent sign, ignores chars between blocks
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inBlk <= 1'b0;
      rxDone <= 1'b0;
      cnt = 0;
    end else begin
      rxDone <= 1'b0;
      if (txValid_q && txReady) begin
        if (txChar_q == 8'h25) begin
          inBlk <= 1'b1;
          cnt = 0;
        end else if (inBlk && (txChar_q == 8'h0d || txChar_q == 8'h0a)) begin
          inBlk <= 1'b0;
          decode();
        end else if (inBlk && cnt < 256) begin
          bufc[cnt] = txChar_q;
          cnt++;
        end
      end
    end
  end
endmodule

// *** bench/hlbd_sender_bench.sv ***
// hlbd_sender_bench: drives block requests and bytes, checks blocks seen by the device model
// assumes: hlbd_sender, hlbd_rx_model and the bound checker compiled before
`timescale 1ns/1ps
module hlbd_sender_bench;
  typedef struct packed {
    logic [3:0] typ; logic [63:0] addr; logic [7:0] cnt; logic [15:0] acc;
  } hlbd_note_s;
  logic                clk_sys;
  logic                rst_n;
  logic                reqValid;
  hlbd_pkg::hlbd_req_s req;
  logic                reqReady_q, reqError_q, byteValid, byteReady_q, txValid_q, txReady;
  logic                blockDone_q, stall, rxDone, rxGood;
  logic [7:0]          byteData, txChar_q, rxCnt;
  logic [3:0]          rxType;
  logic [63:0]         rxAddr, ra;
  logic [15:0]         rxAcc;
  logic [7:0]          bq [0:255];
  hlbd_note_s          expQ [$];
  hlbd_note_s          noteCur;
  int                  nWant, nTaken, errCount, nTests;
  int                  seed = 15;
  hlbd_sender dut (.*);
  hlbd_rx_model u_dev (.*);
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    nTests++;
    if (e !== s) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one request with its bytes; notes the block the device should see
  task automatic send(input hlbd_pkg::hlbd_kind_e k, input logic [63:0] a, input int n,
                      input logic [3:0] st, input logic e);
    logic [15:0] acc; logic got; logic fin;
    acc = 16'h0; got = 1'b0; fin = 1'b0;
    for (int i = 0; i < n; i++) begin
      bq[i] = 8'($random(seed));
      acc = 16'(acc * 16'h3 + 16'(bq[i]));
    end
    @(negedge clk_sys);
    req = '0;
    req.kind = k; req.addr = a; req.nBytes = 8'(n);
    req.secName = {8'h41, 8'h31}; req.secNameLen = 5'h02; req.hasSecDef = (st == 4'h1);
    req.secBase = {$random(seed), $random(seed)}; req.secLen = {32'h0, $random(seed)};
    req.hasSym = (k == hlbd_pkg::HLBD_KIND_SYM); req.symType = st; req.symNameLen = 5'h05;
    req.symName = {88'h0, 8'h5a, 8'h2e, 8'h24, 8'h62, 8'h61}; req.symValue = a;
    nWant = n;
    if (!e && k != hlbd_pkg::HLBD_KIND_ABORT)
      expQ.push_back({(k == hlbd_pkg::HLBD_KIND_DATA) ? 4'h6 :
                      (k == hlbd_pkg::HLBD_KIND_TERM) ? 4'h8 : 4'h3, a, 8'(n), acc});
    while (reqReady_q !== 1'b1) @(negedge clk_sys);
    reqValid = 1'b1;
    @(negedge clk_sys);
    reqValid = 1'b0;
    for (int w = 0; w < 4000 && !fin; w++) begin
      if (reqError_q === 1'b1) got = 1'b1;
      fin = got || (blockDone_q === 1'b1);
      @(negedge clk_sys);
    end
    chk("finished", 64'h1, 64'(fin));
    chk("refused", 64'(e), 64'(got));
  endtask
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // object bytes: count restarts with each taken request
  always @(posedge clk_sys) begin
    if (reqValid && reqReady_q) nTaken <= 0;
    else if (byteValid && byteReady_q) nTaken <= nTaken + 1;
  end
  always @(negedge clk_sys) begin
    byteValid <= (nTaken < nWant);
    byteData <= bq[nTaken[7:0]];
  end
  // takes the oldest note whenever the device reports a block
  always @(negedge clk_sys) begin
    if (rxDone === 1'b1) begin
      if (expQ.size() == 0) chk("unexpected block", 64'h0, 64'h1);
      else begin
        noteCur = expQ.pop_front();
        chk("good", 64'h1, 64'(rxGood));
        chk("type", 64'(noteCur.typ), 64'(rxType));
        chk("addr", noteCur.addr, rxAddr);
        chk("count", 64'(noteCur.cnt), 64'(rxCnt));
        chk("bytes", 64'(noteCur.acc), 64'(rxAcc));
      end
    end
  end
  // watchdog
  initial begin
    #(5ns * 40000);
    errCount++;
    results();
  end
  // main sequence
  initial begin
    rst_n = 1'b0; reqValid = 1'b0; req = '0; byteValid = 1'b0; byteData = 8'h00;
    stall = 1'b0; nWant = 0; nTaken = 0; errCount = 0; nTests = 0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    send(hlbd_pkg::HLBD_KIND_TERM, 64'h5, 0, 4'h0, 1'b1);
    send(hlbd_pkg::HLBD_KIND_DATA, 64'h0, 1, 4'h0, 1'b0);
    stall = 1'b1;
    for (int i = 0; i < 6; i++) begin
      ra = {$random(seed), $random(seed)} >> (i * 10);
      send(hlbd_pkg::HLBD_KIND_DATA, ra, i * 3, 4'h0, 1'b0);
    end
    ra = {$random(seed), $random(seed)} | 64'hf000000000000000;
    send(hlbd_pkg::HLBD_KIND_DATA, ra, 116, 4'h0, 1'b0);
    send(hlbd_pkg::HLBD_KIND_DATA, ra, 117, 4'h0, 1'b1);
    for (int t = 1; t <= 8; t++) send(hlbd_pkg::HLBD_KIND_SYM, 64'h1a, 0, 4'(t), 1'b0);
    send(hlbd_pkg::HLBD_KIND_SYM, 64'h1a, 0, 4'h9, 1'b1);
    send(hlbd_pkg::HLBD_KIND_SYM, 64'h1a, 0, 4'h0, 1'b1);
    send(hlbd_pkg::HLBD_KIND_TERM, ra, 0, 4'h0, 1'b0);
    send(hlbd_pkg::HLBD_KIND_TERM, ra, 0, 4'h0, 1'b1);
    send(hlbd_pkg::HLBD_KIND_DATA, 64'h7f, 2, 4'h0, 1'b0);
    send(hlbd_pkg::HLBD_KIND_ABORT, 64'h0, 0, 4'h0, 1'b0);
    send(hlbd_pkg::HLBD_KIND_TERM, 64'h3, 0, 4'h0, 1'b1);
    send(hlbd_pkg::HLBD_KIND_DATA, 64'h100, 4, 4'h0, 1'b0);
    send(hlbd_pkg::HLBD_KIND_TERM, 64'h100, 0, 4'h0, 1'b0);
    repeat (20) @(negedge clk_sys);
    chk("pending notes", 64'h0, 64'(expQ.size()));
    results();
  end
endmodule

// *** bench/hlbd_sender_sva.sv ***
// hlbd_sender_sva: timing checks on the block sender ports
// assumes: bound to every hlbd_sender, one clock domain
`timescale 1ns/1ps
module hlbd_sender_sva (
  input wire logic                clk_sys,     // clock
  input wire logic                rst_n,       // reset, active low
  input wire logic                reqValid,    // request offered
  input wire hlbd_pkg::hlbd_req_s req,         // request
  input wire logic                reqReady_q,  // request ready
  input wire logic                reqError_q,  // refusal
  input wire logic                byteValid,   // byte offered
  input wire logic [7:0]          byteData,    // byte
  input wire logic                byteReady_q, // byte ready
  input wire logic [7:0]          txChar_q,    // link char
  input wire logic                txValid_q,   // link valid
  input wire logic                txReady,     // link ready
  input wire logic                blockDone_q  // block sent
);
  logic [8:0] idx_q;
  logic [8:0] idx_d;
  logic       take;
  logic       isHex;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // position of the shown character since the percent sign, zero outside blocks
  assign take = txValid_q && txReady;
  assign isHex = (txChar_q >= 8'h30 && txChar_q <= 8'h39) || (txChar_q >= 8'h41 && txChar_q <= 8'h46);
  always_comb begin
    idx_d = idx_q;
    if (take) idx_d = (txChar_q == 8'h25) ? 9'h001 : (txChar_q == 8'h0a || idx_q == 9'h000) ? 9'h000 : idx_q + 9'h001;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) idx_q <= 9'h000;
    else idx_q <= idx_d;
  end
  // link and request relations
  property p_txHold; txValid_q && !txReady |=> txValid_q && $stable(txChar_q); endproperty
  property p_lenHex; take && txChar_q == 8'h25 |=> txValid_q && isHex ##0 (!take or ##1 isHex); endproperty
  property p_type; txValid_q && idx_q == 9'h003 |-> txChar_q inside {8'h36, 8'h33, 8'h38}; endproperty
  property p_ckHex; txValid_q && (idx_q == 9'h004 || idx_q == 9'h005) |-> isHex; endproperty
  property p_size; txValid_q && txChar_q != 8'h0d && txChar_q != 8'h0a |-> idx_q <= 9'h0fe; endproperty
  property p_crLf; take && txChar_q == 8'h0d |=> txValid_q && txChar_q == 8'h0a; endproperty
  property p_done; take && txChar_q == 8'h0a |-> ##[1:2] blockDone_q; endproperty
  property p_reqOne; reqValid && reqReady_q |=> !reqReady_q; endproperty
  property p_idle; reqReady_q |-> !txValid_q; endproperty
  property p_byte; byteValid && byteReady_q |=> !byteReady_q; endproperty
  property p_start; $rose(txValid_q) |-> txChar_q == 8'h25 || txChar_q == 8'h2f; endproperty
  a_txHold: assert property (p_txHold) else $error("link char changed while stalled");
  a_lenHex: assert property (p_lenHex) else $error("length digit not hex");
  a_type: assert property (p_type) else $error("bad block type digit");
  a_ckHex: assert property (p_ckHex) else $error("checksum digit not hex");
  a_size: assert property (p_size) else $error("block longer than allowed");
  a_crLf: assert property (p_crLf) else $error("line feed missing after return");
  a_done: assert property (p_done) else $error("block end not reported");
  a_reqOne: assert property (p_reqOne) else $error("ready stayed high after take");
  a_idle: assert property (p_idle) else $error("link active while idle");
  a_byte: assert property (p_byte) else $error("byte ready stayed high after take");
  a_start: assert property (p_start) else $error("block opened with wrong char");
  c_sym: cover property (reqValid && reqReady_q && req.kind == hlbd_pkg::HLBD_KIND_SYM);
  c_err: cover property (reqError_q);
  c_full: cover property (txValid_q && idx_q == 9'h0fe);
  c_done: cover property (blockDone_q);
endmodule
bind hlbd_sender hlbd_sender_sva u_sva (.*);

// *** core/hlbd_char_value.sv ***
// hlbd_char_value: maps one stream character to its checksum value
// assumes: purely combinational, used by the sender for every body character
`timescale 1ns/1ps
`include "hlbd_regs.svh"

module hlbd_char_value (
  input  wire logic [7:0] ch,    // character
  output logic      [6:0] val,   // checksum value
  output logic            legal  // character belongs to the block set
);

  // class lookup by character range
  always_comb begin
    val   = 7'h00;
    legal = 1'b1;
    if (ch >= `HLBD_CH_DIG0 && ch <= `HLBD_CH_DIG9) begin
      val = 7'(ch - `HLBD_CH_DIG0);
    end else if (ch >= `HLBD_CH_UPA && ch <= `HLBD_CH_UPZ) begin
      val = 7'(ch - `HLBD_CH_UPA) + `HLBD_VAL_UPA;
    end else if (ch >= `HLBD_CH_LOA && ch <= `HLBD_CH_LOZ) begin
      val = 7'(ch - `HLBD_CH_LOA) + `HLBD_VAL_LOA;
    end else if (ch == `HLBD_CH_DOLLAR) begin
      val = `HLBD_VAL_DOLLAR;
    end else if (ch == `HLBD_CH_PCT) begin
      val = `HLBD_VAL_PCT;
    end else if (ch == `HLBD_CH_DOT) begin
      val = `HLBD_VAL_DOT;
    end else if (ch == `HLBD_CH_USCORE) begin
      val = `HLBD_VAL_USCORE;
    end else begin
      legal = 1'b0;
    end
  end

endmodule

// *** core/hlbd_pkg.sv ***
// hlbd_pkg: types of the load-block sender
// assumes: used by name, never imported
package hlbd_pkg;

  typedef enum logic [2:0] {
    HLBD_KIND_DATA  = 3'b000,
    HLBD_KIND_TERM  = 3'b001,
    HLBD_KIND_SYM   = 3'b010,
    HLBD_KIND_ABORT = 3'b011
  } hlbd_kind_e;

  typedef enum logic [1:0] {
    HLBD_S_IDLE  = 2'b00,
    HLBD_S_BUILD = 2'b01,
    HLBD_S_EMIT  = 2'b10
  } hlbd_state_e;

  typedef enum logic [2:0] {
    HLBD_STEP_LEAD    = 3'b000,
    HLBD_STEP_BODY    = 3'b001,
    HLBD_STEP_BASE    = 3'b010,
    HLBD_STEP_SECLEN  = 3'b011,
    HLBD_STEP_SYMTYPE = 3'b100,
    HLBD_STEP_SYMNAME = 3'b101,
    HLBD_STEP_VALUE   = 3'b110,
    HLBD_STEP_END     = 3'b111
  } hlbd_step_e;

  typedef enum logic [2:0] {
    HLBD_F_NUM  = 3'b000,
    HLBD_F_STR  = 3'b001,
    HLBD_F_CHR  = 3'b010,
    HLBD_F_DATA = 3'b011,
    HLBD_F_SKIP = 3'b100,
    HLBD_F_END  = 3'b101
  } hlbd_fld_e;

  // one block request; name character k sits at bits [8k+7:8k]
  typedef struct packed {
    hlbd_kind_e   kind;
    logic [63:0]  addr;
    logic [7:0]   nBytes;
    logic [127:0] secName;
    logic [4:0]   secNameLen;
    logic         hasSecDef;
    logic [63:0]  secBase;
    logic [63:0]  secLen;
    logic         hasSym;
    logic [3:0]   symType;
    logic [127:0] symName;
    logic [4:0]   symNameLen;
    logic [63:0]  symValue;
  } hlbd_req_s;

endpackage

// *** core/hlbd_regs.svh ***
// hlbd_regs.svh: character codes, limits and emit positions of the block sender
// assumes: included by the sender and its helper, definitions only
`ifndef HLBD_REGS_SVH
`define HLBD_REGS_SVH

// characters placed on the stream
`define HLBD_CH_PCT      8'h25
`define HLBD_CH_CR       8'h0d
`define HLBD_CH_LF       8'h0a
`define HLBD_CH_ZERO     8'h30
`define HLBD_CH_ABORT    8'h2f
`define HLBD_HEX_ALPHA   8'h37
`define HLBD_HEX_TEN     4'ha

// block type digits
`define HLBD_TYPE_DATA   4'h6
`define HLBD_TYPE_SYM    4'h3
`define HLBD_TYPE_TERM   4'h8

// block sizing: counted header part, largest body, largest field
`define HLBD_HDR_COUNTED 8'h05
`define HLBD_BODY_MAX    10'h0f9
`define HLBD_FIELD_MAX   5'h10
`define HLBD_NAME_MIN    5'h01
`define HLBD_SYMTYPE_MIN 4'h1
`define HLBD_SYMTYPE_MAX 4'h8

// emit positions within a block
`define HLBD_IDX_PCT     9'h000
`define HLBD_IDX_LENHI   9'h001
`define HLBD_IDX_LENLO   9'h002
`define HLBD_IDX_TYPE    9'h003
`define HLBD_IDX_CKHI    9'h004
`define HLBD_IDX_CKLO    9'h005
`define HLBD_IDX_BODY    9'h006

// character value classes
`define HLBD_CH_DIG0     8'h30
`define HLBD_CH_DIG9     8'h39
`define HLBD_CH_UPA      8'h41
`define HLBD_CH_UPZ      8'h5a
`define HLBD_CH_LOA      8'h61
`define HLBD_CH_LOZ      8'h7a
`define HLBD_CH_DOLLAR   8'h24
`define HLBD_CH_DOT      8'h2e
`define HLBD_CH_USCORE   8'h5f
`define HLBD_VAL_UPA     7'h0a
`define HLBD_VAL_DOLLAR  7'h24
`define HLBD_VAL_PCT     7'h25
`define HLBD_VAL_DOT     7'h26
`define HLBD_VAL_USCORE  7'h27
`define HLBD_VAL_LOA     7'h28

`endif

// *** core/hlbd_sender.sv ***
// hlbd_sender: builds and sends hex object-load blocks character by character
// assumes: one clock, sink takes a character when txValid_q and txReady are both high
`timescale 1ns/1ps
`include "hlbd_regs.svh"

// Operation
// - percent, five-char header, end-of-line
// - block at most 255 characters
// - two hex digits count block characters
// - type digit 6 data, 3 symbol, 8 end
// - checksum is mod-256 value sum
// - variable fields span 2 to 17 characters
// - data blocks first, one termination last; termination only needs a data block since the last termination or abort
// - symbol block starts with section name
// - section definition: zero, base, length
// - one section definition per section; not checked, hasSecDef is sent as requested
// - names one to sixteen legal characters; only the length is checked, not the characters
// - abandon transfer with older abort block
module hlbd_sender (
  input  wire logic              clk_sys,     // system clock
  input  wire logic              rst_n,       // async reset, active low
  input  wire logic              reqValid,    // block request offered
  input  wire hlbd_pkg::hlbd_req_s req,       // block request contents
  output logic                   reqReady_q,  // request may be taken
  output logic                   reqError_q,  // pulse: request refused
  input  wire logic              byteValid,   // object byte offered
  input  wire logic [7:0]        byteData,    // object byte
  output logic                   byteReady_q, // object byte may be taken
  output logic [7:0]             txChar_q,    // character to the link
  output logic                   txValid_q,   // character valid
  input  wire logic              txReady,     // link takes character
  output logic                   blockDone_q  // pulse: block fully sent
);

  hlbd_pkg::hlbd_state_e state_q, state_d;
  hlbd_pkg::hlbd_step_e  step_q, step_d;
  hlbd_pkg::hlbd_req_s   req_q, req_d;
  hlbd_pkg::hlbd_fld_e   fld;
  logic [8:0]  pos_q, pos_d, idx_q, idx_d;
  logic [7:0]  bodyLen_q, bodyLen_d, sum_q, sum_d;
  logic [3:0]  loNib_q, loNib_d;
  logic        sawData_q, sawData_d;
  logic        reqReady_d, reqError_d, byteReady_d, txValid_d, blockDone_d;
  logic [7:0]  txChar_d;
  logic [7:0]  bodyMem [0:255];
  logic [63:0] numVal;
  logic [127:0] strVal;
  logic [4:0]  strLen, numLen;
  logic [7:0]  chr, bodyChar, lenCount, ckSum, emitChar;
  logic        emitBody, fieldLast, reqOk;
  logic [6:0]  chVal;
  logic [9:0]  dataNeed;
  logic [8:0]  lastIdx;

  // count of significant nibbles, at least one
  function automatic logic [4:0] nibCount(input logic [63:0] v);
    logic [4:0] n;
    n = 5'h01;
    for (int i = 0; i < 16; i++) begin
      if (v[4*i +: 4] != 4'h0) n = 5'(i + 1);
    end
    return n;
  endfunction

  function automatic logic [7:0] hexChar(input logic [3:0] nib);
    return (nib < `HLBD_HEX_TEN) ? (`HLBD_CH_ZERO + {4'h0, nib})
                                 : (`HLBD_HEX_ALPHA + {4'h0, nib});
  endfunction

  function automatic logic [3:0] typeDigit(input hlbd_pkg::hlbd_kind_e k);
    logic [3:0] t;
    t = `HLBD_TYPE_DATA;
    if (k == hlbd_pkg::HLBD_KIND_SYM) t = `HLBD_TYPE_SYM;
    if (k == hlbd_pkg::HLBD_KIND_TERM) t = `HLBD_TYPE_TERM;
    return t;
  endfunction

  // checksum value of each body character
  hlbd_char_value u_value (
    .ch    (bodyChar),
    .val   (chVal),
    .legal ()
  );

  // field layout per block kind and step
  always_comb begin
    fld    = hlbd_pkg::HLBD_F_END;
    numVal = req_q.addr;
    strVal = req_q.secName;
    strLen = req_q.secNameLen;
    chr    = `HLBD_CH_ZERO;
    unique case (req_q.kind)
      hlbd_pkg::HLBD_KIND_DATA: begin
        if (step_q == hlbd_pkg::HLBD_STEP_LEAD) fld = hlbd_pkg::HLBD_F_NUM;
        if (step_q == hlbd_pkg::HLBD_STEP_BODY) begin
          fld = (req_q.nBytes == 8'h00) ? hlbd_pkg::HLBD_F_SKIP
                                        : hlbd_pkg::HLBD_F_DATA;
        end
      end
      hlbd_pkg::HLBD_KIND_TERM: begin
        if (step_q == hlbd_pkg::HLBD_STEP_LEAD) fld = hlbd_pkg::HLBD_F_NUM;
      end
      hlbd_pkg::HLBD_KIND_SYM: begin
        unique case (step_q)
          hlbd_pkg::HLBD_STEP_LEAD: fld = hlbd_pkg::HLBD_F_STR;
          hlbd_pkg::HLBD_STEP_BODY: begin
            fld = req_q.hasSecDef ? hlbd_pkg::HLBD_F_CHR : hlbd_pkg::HLBD_F_SKIP;
          end
          hlbd_pkg::HLBD_STEP_BASE: begin
            numVal = req_q.secBase;
            fld = req_q.hasSecDef ? hlbd_pkg::HLBD_F_NUM : hlbd_pkg::HLBD_F_SKIP;
          end
          hlbd_pkg::HLBD_STEP_SECLEN: begin
            numVal = req_q.secLen;
            fld = req_q.hasSecDef ? hlbd_pkg::HLBD_F_NUM : hlbd_pkg::HLBD_F_SKIP;
          end
          hlbd_pkg::HLBD_STEP_SYMTYPE: begin
            chr = hexChar(req_q.symType);
            fld = req_q.hasSym ? hlbd_pkg::HLBD_F_CHR : hlbd_pkg::HLBD_F_SKIP;
          end
          hlbd_pkg::HLBD_STEP_SYMNAME: begin
            strVal = req_q.symName;
            strLen = req_q.symNameLen;
            fld = req_q.hasSym ? hlbd_pkg::HLBD_F_STR : hlbd_pkg::HLBD_F_SKIP;
          end
          hlbd_pkg::HLBD_STEP_VALUE: begin
            numVal = req_q.symValue;
            fld = req_q.hasSym ? hlbd_pkg::HLBD_F_NUM : hlbd_pkg::HLBD_F_SKIP;
          end
          hlbd_pkg::HLBD_STEP_END: fld = hlbd_pkg::HLBD_F_END;
        endcase
      end
      hlbd_pkg::HLBD_KIND_ABORT: begin
        chr = `HLBD_CH_ABORT;
        if (step_q == hlbd_pkg::HLBD_STEP_LEAD || step_q == hlbd_pkg::HLBD_STEP_BODY) begin
          fld = hlbd_pkg::HLBD_F_CHR;
        end
      end
      default: fld = hlbd_pkg::HLBD_F_END;
    endcase
  end

  // request checks: kind, name lengths, symbol type, data fit, block order
  always_comb begin
    dataNeed = {5'h00, nibCount(req.addr)} + 10'h001 + {1'b0, req.nBytes, 1'b0};
    reqOk = 1'b1;
    unique case (req.kind)
      hlbd_pkg::HLBD_KIND_DATA: reqOk = (dataNeed <= `HLBD_BODY_MAX);
      hlbd_pkg::HLBD_KIND_TERM: reqOk = sawData_q;
      hlbd_pkg::HLBD_KIND_SYM: begin
        reqOk = (req.secNameLen >= `HLBD_NAME_MIN) && (req.secNameLen <= `HLBD_FIELD_MAX);
        if (req.hasSym) begin
          reqOk = reqOk && (req.symNameLen >= `HLBD_NAME_MIN)
                  && (req.symNameLen <= `HLBD_FIELD_MAX)
                  && (req.symType >= `HLBD_SYMTYPE_MIN)
                  && (req.symType <= `HLBD_SYMTYPE_MAX);
        end
      end
      hlbd_pkg::HLBD_KIND_ABORT: reqOk = 1'b1;
      default: reqOk = 1'b0;
    endcase
  end

  // header fields and next character of the emit phase
  always_comb begin
    lenCount = `HLBD_HDR_COUNTED + bodyLen_q;
    ckSum    = sum_q + {4'h0, lenCount[7:4]} + {4'h0, lenCount[3:0]}
               + {4'h0, typeDigit(req_q.kind)};
    lastIdx  = `HLBD_IDX_BODY + {1'b0, bodyLen_q};
    unique case (idx_q)
      `HLBD_IDX_PCT:   emitChar = `HLBD_CH_PCT;
      `HLBD_IDX_LENHI: emitChar = hexChar(lenCount[7:4]);
      `HLBD_IDX_LENLO: emitChar = hexChar(lenCount[3:0]);
      `HLBD_IDX_TYPE:  emitChar = hexChar(typeDigit(req_q.kind));
      `HLBD_IDX_CKHI:  emitChar = hexChar(ckSum[7:4]);
      `HLBD_IDX_CKLO:  emitChar = hexChar(ckSum[3:0]);
      default: begin
        if (idx_q < lastIdx) emitChar = bodyMem[8'(idx_q - `HLBD_IDX_BODY)];
        else if (idx_q == lastIdx) emitChar = `HLBD_CH_CR;
        else emitChar = `HLBD_CH_LF;
      end
    endcase
  end

  // sequencer: take request, build body, then send the block
  always_comb begin
    state_d = state_q;  step_d = step_q;  req_d = req_q;  pos_d = pos_q;
    idx_d = idx_q;  bodyLen_d = bodyLen_q;  sum_d = sum_q;  loNib_d = loNib_q;
    sawData_d = sawData_q;  reqReady_d = reqReady_q;  reqError_d = 1'b0;
    byteReady_d = byteReady_q;  txValid_d = txValid_q;  txChar_d = txChar_q;
    blockDone_d = 1'b0;  emitBody = 1'b0;  fieldLast = 1'b0;  bodyChar = chr;
    numLen = nibCount(numVal);
    unique case (state_q)
      hlbd_pkg::HLBD_S_IDLE: begin
        reqReady_d = 1'b1;
        if (reqValid && reqReady_q) begin
          reqReady_d = 1'b0;
          if (reqOk) begin
            req_d = req;
            state_d = hlbd_pkg::HLBD_S_BUILD;
            step_d = hlbd_pkg::HLBD_STEP_LEAD;
            pos_d = 9'h000;
            bodyLen_d = 8'h00;
            sum_d = 8'h00;
          end else begin
            reqError_d = 1'b1;
          end
        end
      end
      hlbd_pkg::HLBD_S_BUILD: begin
        unique case (fld)
          hlbd_pkg::HLBD_F_NUM: begin
            emitBody = 1'b1;
            fieldLast = (pos_q[4:0] == numLen);
            if (pos_q == 9'h000) bodyChar = hexChar(numLen[3:0]);
            else bodyChar = hexChar(4'(numVal >> {5'(numLen - pos_q[4:0]), 2'b00}));
          end
          hlbd_pkg::HLBD_F_STR: begin
            emitBody = 1'b1;
            fieldLast = (pos_q[4:0] == strLen);
            // names go out as given, upper and lower case keep distinct checksum values
            if (pos_q == 9'h000) bodyChar = hexChar(strLen[3:0]);
            else bodyChar = 8'(strVal >> {4'(pos_q[4:0] - 5'h01), 3'b000});
          end
          hlbd_pkg::HLBD_F_CHR: begin
            emitBody = 1'b1;
            fieldLast = 1'b1;
          end
          hlbd_pkg::HLBD_F_DATA: begin
            fieldLast = (pos_q == ({req_q.nBytes, 1'b0} - 9'h001));
            if (pos_q[0]) begin
              emitBody = 1'b1;
              bodyChar = hexChar(loNib_q);
            end else if (byteReady_q && byteValid) begin
              emitBody = 1'b1;
              byteReady_d = 1'b0;
              bodyChar = hexChar(byteData[7:4]);
              loNib_d = byteData[3:0];
            end else begin
              byteReady_d = 1'b1;
            end
          end
          hlbd_pkg::HLBD_F_SKIP: begin
            step_d = hlbd_pkg::hlbd_step_e'(step_q + 3'b001);
          end
          hlbd_pkg::HLBD_F_END: begin
            state_d = hlbd_pkg::HLBD_S_EMIT;
            idx_d = (req_q.kind == hlbd_pkg::HLBD_KIND_ABORT) ? `HLBD_IDX_BODY
                                                             : `HLBD_IDX_PCT;
          end
          default: state_d = hlbd_pkg::HLBD_S_IDLE;
        endcase
        if (emitBody) begin
          bodyLen_d = bodyLen_q + 8'h01;
          sum_d = sum_q + {1'b0, chVal};
          if (fieldLast) begin
            step_d = hlbd_pkg::hlbd_step_e'(step_q + 3'b001);
            pos_d = 9'h000;
          end else begin
            pos_d = pos_q + 9'h001;
          end
        end
      end
      hlbd_pkg::HLBD_S_EMIT: begin
        if (!txValid_q || txReady) begin
          if (idx_q <= lastIdx + 9'h001) begin
            txChar_d = emitChar;
            txValid_d = 1'b1;
            idx_d = idx_q + 9'h001;
          end else begin
            txValid_d = 1'b0;
            blockDone_d = 1'b1;
            state_d = hlbd_pkg::HLBD_S_IDLE;
            if (req_q.kind == hlbd_pkg::HLBD_KIND_DATA) sawData_d = 1'b1;
            if (req_q.kind != hlbd_pkg::HLBD_KIND_DATA &&
                req_q.kind != hlbd_pkg::HLBD_KIND_SYM) sawData_d = 1'b0;
          end
        end
      end
      default: state_d = hlbd_pkg::HLBD_S_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= hlbd_pkg::HLBD_S_IDLE;
      step_q <= hlbd_pkg::HLBD_STEP_LEAD;
      req_q <= '0;
      pos_q <= 9'h000;
      idx_q <= 9'h000;
      bodyLen_q <= 8'h00;
      sum_q <= 8'h00;
      loNib_q <= 4'h0;
      sawData_q <= 1'b0;
      reqReady_q <= 1'b0;
      reqError_q <= 1'b0;
      byteReady_q <= 1'b0;
      txValid_q <= 1'b0;
      txChar_q <= 8'h00;
      blockDone_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      req_q <= req_d;
      pos_q <= pos_d;
      idx_q <= idx_d;
      bodyLen_q <= bodyLen_d;
      sum_q <= sum_d;
      loNib_q <= loNib_d;
      sawData_q <= sawData_d;
      reqReady_q <= reqReady_d;
      reqError_q <= reqError_d;
      byteReady_q <= byteReady_d;
      txValid_q <= txValid_d;
      txChar_q <= txChar_d;
      blockDone_q <= blockDone_d;
    end
  end

  // body store, written while building
  always_ff @(posedge clk_sys) begin
    if (emitBody) bodyMem[bodyLen_q] <= bodyChar;
  end

endmodule
